/* File: hw/psarb_map.svh */
`ifndef PSARB_MAP_SVH
`define PSARB_MAP_SVH
// Register offsets on the plain register port
`define PSARB_OFS_CTRL   4'h0
`define PSARB_OFS_STATUS 4'h1
// Control register layout: bits 6:0 group (1 = low group), bit 8 parking
`define PSARB_CTRL_GRP_LSB  0
`define PSARB_CTRL_GRP_MSB  6
`define PSARB_CTRL_PARK_BIT 8
// Reset value: all high group, park on the bridge
`define PSARB_CTRL_RESET 16'h0000
// Requester count and index of the internal bridge master
`define PSARB_NREQ     7
`define PSARB_BRIDGE   3'h6
// Reset grant (bridge) and rotation pointer start, so index 0 wins first
`define PSARB_GNT_RESET 7'h40
`define PSARB_PTR_RESET 3'h6
// Value driven on idle lines while parked on the bridge
`define PSARB_IDLE_AD  32'h00000000
`define PSARB_IDLE_CBE 4'h0
`define PSARB_IDLE_PAR 1'b0
`endif

/* File: hw/psarb_pkg.sv */
package psarb_pkg;
	// Arbiter phases
	typedef enum logic [1:0] {
		PSARB_IDLE  = 2'b00,
		PSARB_OWNED = 2'b01,
		PSARB_PARK  = 2'b11
	} psarb_state_e;
	// Register port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} psarb_reg_s;
	// Idle bus drive group
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0]  cbe_n;
		logic        par;
		logic        oe;
	} psarb_idle_s;
endpackage : psarb_pkg

/* File: hw/psarb_arbiter.sv */
`timescale 1ns/1ps
`include "psarb_map.svh"
// Overview of operation
// [RULE1] Seven requesters are arbitrated: six external masters and the bridge.
// [RULE2] Software puts each requester in the high or low group by its own bit.
// [RULE3] Arbitration works even when all requesters sit in one group.
// [RULE4] Within a group the grant rotates round robin past the last winner.
// [RULE5] The low group takes one slot of the high rotation and grants its next member; the code gives it the slot after each high grant.
// [RULE6] A 16-bit control register holds group bits and the parking choice.
// [RULE7] With no request the bus parks on the last owner or on the bridge.
// [RULE8] Reset selects bridge parking, and bridge parking drives idle lines.
// [RULE9] At most one grant is active and it moves only while the bus is idle.
// [RULE10] A master requests low and starts only when granted with the bus idle.
module psarb_arbiter
	import psarb_pkg::*;
(
	// Clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	// Register port
	input  wire psarb_reg_s        i_reg,
	output logic [15:0]            o_rdata,
	// Requests and grants, active low; bit 6 is the bridge
	input  wire logic [6:0]        i_req_n,
	output logic [6:0]             o_gnt_n,
	// Bus idle: no frame and no irdy
	input  wire logic              i_bus_idle,
	// Idle line drive while parked on the bridge
	output psarb_idle_s            o_idle
);
	logic [15:0]  ctrl;
	logic [6:0]   gnt;
	logic [2:0]   last_hi;
	logic [2:0]   last_lo;
	logic         lo_slot_last;
	psarb_state_e state;
	logic [6:0]   req;
	logic [6:0]   low;
	logic [6:0]   hi_req;
	logic [6:0]   lo_req;
	logic         park_last;
	logic [2:0]   hi_pick;
	logic         hi_found;
	logic [2:0]   lo_pick;
	logic         lo_found;
	logic [6:0]   next_gnt;
	psarb_state_e next_state;

	assign req       = ~i_req_n; // [RULE1] [RULE10]
	assign low       = ctrl[`PSARB_CTRL_GRP_MSB:`PSARB_CTRL_GRP_LSB]; // [RULE2]
	assign park_last = ctrl[`PSARB_CTRL_PARK_BIT];

	// Per-requester group masks; a requester sits in exactly one group
	for (genvar i = 0; i < `PSARB_NREQ; i++) begin : g_mask
		assign hi_req[i] = req[i] & ~low[i]; // [RULE2]
		assign lo_req[i] = req[i] & low[i];  // [RULE2]
	end

	// Round-robin search within each group, starting past the last winner
	always_comb begin
		logic [2:0] idx;
		idx      = 3'h0;
		hi_pick  = 3'h0;
		hi_found = 1'b0;
		lo_pick  = 3'h0;
		lo_found = 1'b0;
		// Sum in 32 bits so the wrap is done by the modulo, not by overflow
		for (int k = 1; k <= `PSARB_NREQ; k++) begin
			idx = 3'((32'(last_hi) + 32'(k)) % `PSARB_NREQ);
			if (!hi_found && hi_req[idx]) begin // [RULE4]
				hi_pick  = idx;
				hi_found = 1'b1;
			end
		end
		for (int k = 1; k <= `PSARB_NREQ; k++) begin
			idx = 3'((32'(last_lo) + 32'(k)) % `PSARB_NREQ);
			if (!lo_found && lo_req[idx]) begin // [RULE4]
				lo_pick  = idx;
				lo_found = 1'b1;
			end
		end
	end

	// Choose next grant; the low group takes the slot after each high grant,
	// and a group with no request simply drops out.
	always_comb begin
		next_gnt   = gnt;
		next_state = state;
		if (i_bus_idle) begin // [RULE9]
			if (hi_found && (lo_slot_last || !lo_found)) begin // [RULE5]
				next_gnt   = 7'h01 << hi_pick;
				next_state = PSARB_OWNED;
			end else if (lo_found) begin // [RULE3] [RULE5]
				next_gnt   = 7'h01 << lo_pick;
				next_state = PSARB_OWNED;
			end else if (!park_last) begin // [RULE7]
				next_gnt   = 7'h01 << `PSARB_BRIDGE;
				next_state = PSARB_PARK;
			end else begin
				next_state = PSARB_IDLE; // Keep last owner's grant
			end
		end
	end

	// Grant register; a single one-hot grant at all times
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gnt   <= `PSARB_GNT_RESET; // [RULE8]
			state <= PSARB_PARK;
		end else begin
			gnt   <= next_gnt; // [RULE9]
			state <= next_state;
		end
	end

	// Rotation pointers, advanced only when a new winner is taken
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			last_hi      <= `PSARB_PTR_RESET;
			last_lo      <= `PSARB_PTR_RESET;
			lo_slot_last <= 1'b0;
		end else if (i_bus_idle) begin
			if (hi_found && (lo_slot_last || !lo_found)) begin
				last_hi      <= hi_pick; // [RULE4]
				lo_slot_last <= 1'b0;
			end else if (lo_found) begin
				last_lo      <= lo_pick; // [RULE5]
				lo_slot_last <= 1'b1;
			end
		end
	end

	// Group order checks: the low group answers alone, then yields a slot
	AST_LO_ALONE: assert property ( // [RULE3]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus_idle && req != 7'h00 && hi_req == 7'h00)
		|=> (gnt & $past(low)) != 7'h00)
		else $error("low group not served alone");
	AST_HI_AFTER_LO: assert property ( // [RULE5]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus_idle && lo_slot_last && hi_req != 7'h00)
		|=> (gnt & ~$past(low)) != 7'h00)
		else $error("high group skipped after low slot");
	AST_OWNED: assert property ( // [RULE1]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus_idle && req != 7'h00) |=> state == PSARB_OWNED)
		else $error("request left without owner");
	AST_PARK_STATE: assert property ( // [RULE7]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus_idle && req == 7'h00 && !park_last) |=> state == PSARB_PARK)
		else $error("not parked on bridge");

	// Control register write; reset parks on the bridge
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= `PSARB_CTRL_RESET; // [RULE6] [RULE8]
		end else if (i_reg.wr && i_reg.addr == `PSARB_OFS_CTRL) begin
			ctrl <= i_reg.wdata; // [RULE6]
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 16'h0000;
		end else if (i_reg.rd && i_reg.addr == `PSARB_OFS_CTRL) begin
			o_rdata <= ctrl;
		end else if (i_reg.rd && i_reg.addr == `PSARB_OFS_STATUS) begin
			o_rdata <= {6'h00, state, 1'b0, gnt};
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	// Register port checks: read data stand one cycle, status is read-only
	AST_RDATA_IDLE: assert property ( // [RULE6]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!$past(i_reg.rd) |-> o_rdata == 16'h0000)
		else $error("read data outside its cycle");
	AST_STATUS_RO: assert property ( // [RULE6]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg.wr && i_reg.addr == `PSARB_OFS_STATUS) |=> $stable(ctrl))
		else $error("status write changed control");

	// Idle drive while parked on the bridge keeps lines from floating
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_idle <= '0;
		end else begin
			o_idle.ad    <= `PSARB_IDLE_AD;
			o_idle.cbe_n <= `PSARB_IDLE_CBE;
			o_idle.par   <= `PSARB_IDLE_PAR; // Even parity over zeros
			o_idle.oe    <= (next_state == PSARB_PARK) && i_bus_idle; // [RULE8]
		end
	end

	// The bridge must never drive the idle lines while a master owns the bus
	AST_IDLE_OE: assert property ( // [RULE8]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus_idle && req == 7'h00 && !park_last) |=> o_idle.oe)
		else $error("idle lines not driven while parked");
	AST_OE_OFF: assert property ( // [RULE8]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!i_bus_idle |=> !o_idle.oe)
		else $error("idle lines driven during a transfer");

	assign o_gnt_n = ~gnt;

	// Grant path checks
	AST_ONE_GRANT: assert property ( // [RULE9]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		$onehot(~o_gnt_n))
		else $error("grant not one-hot");
	AST_MOVE_IDLE: assert property ( // [RULE9]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!$past(i_bus_idle) |-> $stable(o_gnt_n))
		else $error("grant moved during busy bus");
	AST_PARK_BRIDGE: assert property ( // [RULE7]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus_idle && i_req_n == 7'h7f && !park_last) |=> !o_gnt_n[6])
		else $error("no bridge park");
	AST_PARK_LAST: assert property ( // [RULE7]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_req_n == 7'h7f && park_last) |=> $stable(o_gnt_n))
		else $error("park on last failed");
	AST_GRANT_REQ: assert property ( // [RULE1] [RULE3]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus_idle && i_req_n != 7'h7f)
		|=> ((~o_gnt_n & ~$past(i_req_n)) != 7'h00))
		else $error("grant to non-requester");
	AST_HI_ROTATE: assert property ( // [RULE4]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus_idle && low == 7'h00 && req == 7'h03 && gnt == 7'h01)
		|=> o_gnt_n == 7'h7d)
		else $error("no rotation");
	AST_LO_SLOT: assert property ( // [RULE5]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_bus_idle && low == 7'h02 && req == 7'h03 && gnt == 7'h01)
		|=> o_gnt_n == 7'h7d)
		else $error("low slot skipped");
	AST_IDLE_DRIVE: assert property ( // [RULE8]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		o_idle.oe |-> (!o_gnt_n[6] && o_idle.ad == `PSARB_IDLE_AD))
		else $error("idle drive without bridge park");
	AST_CTRL_WR: assert property ( // [RULE6] [RULE2]
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_reg.wr && i_reg.addr == `PSARB_OFS_CTRL)
		|=> ctrl == $past(i_reg.wdata))
		else $error("control write lost");
endmodule : psarb_arbiter

/* File: sim/psarb_master_model.sv */
`timescale 1ns/1ps
// Far-side masters: request by level, run a short burst once granted
module psarb_master_model (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	// Wishes from the bench, grants from the arbiter
	input  wire logic [6:0] i_want,
	input  wire logic [6:0] i_gnt_n,
	// Request lines and bus state
	output logic      [6:0] o_req_n,
	output logic            o_bus_idle
);
	logic [1:0] busy;
	assign o_req_n    = ~i_want;
	assign o_bus_idle = (busy == 2'h0);
	// Start only when granted and the bus is free; burst is three cycles
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) busy <= 2'h0;
		else if (busy != 2'h0) busy <= busy - 2'h1;
		else if (|(~i_gnt_n & i_want)) busy <= 2'h3;
	end
endmodule : psarb_master_model

/* File: sim/pci_segment_arbiter_bench.sv */
`timescale 1ns/1ps
module pci_segment_arbiter_bench;
	import psarb_pkg::*;
	logic        clk, rst_n, idle;
	psarb_reg_s  rq;
	psarb_idle_s oi;
	logic [15:0] rdata, ctrl;
	logic [6:0]  want, req_n, gnt_n, exp, hi, lo;
	logic [31:0] lfsr;
	int          fail_count, num_checks, cyc, g, phi, plo, lastlo;
	psarb_arbiter uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg(rq),
		.o_rdata(rdata), .i_req_n(req_n), .o_gnt_n(gnt_n),
		.i_bus_idle(idle), .o_idle(oi));
	psarb_master_model far (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_want(want), .i_gnt_n(gnt_n), .o_req_n(req_n), .o_bus_idle(idle));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task check(input logic [15:0] got, input logic [15:0] e);
		num_checks++;
		if (got !== e) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, e);
		end
	endtask : check
	function automatic int pick(input logic [6:0] m, input int p);
		for (int k = 1; k <= 7; k++) if (m[(p + k) % 7]) return (p + k) % 7;
		return p;
	endfunction : pick
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	// Reference arbiter: predicts the grant the next idle edge will give
	always @(negedge clk) if (rst_n) begin
		check({9'h0, gnt_n}, {9'h0, exp});
		if (idle) begin
			hi = ~req_n & ~ctrl[6:0];
			lo = ~req_n & ctrl[6:0];
			if ((hi | lo) == 7'h0) begin
				if (!ctrl[8]) g = 6;
			end else if (lo != 7'h0 && (hi == 7'h0 || lastlo == 0)) begin
				g = pick(lo, plo);
				plo = g;
				lastlo = 1;
			end else begin
				g = pick(hi, phi);
				phi = g;
				lastlo = 0;
			end
			exp = ~(7'h1 << g);
		end
	end
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk) rq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) rq <= '0;
		if (a == 4'h0) ctrl <= d; // Mirror lands with the design's register
	endtask : wr
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk) rq <= '{a, 16'h0, 1'b0, 1'b1};
		@(posedge clk) rq <= '0;
		#1 check(rdata, e);
	endtask : rd
	// Random request mixes, then a quiet spell so the bus drains
	task run(input int n);
		repeat (n) begin
			repeat (3) @(posedge clk);
			lfsr = lfsr_next(lfsr);
			want <= lfsr[6:0];
		end
		want <= 7'h0;
		repeat (10) @(posedge clk);
	endtask : run
	task report_and_stop;
		$display("Checks %0d, errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// Hang guard, well above the three phases of traffic
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			report_and_stop;
		end
	end
	initial begin
		rst_n = 1'b0;
		want = 7'h0;
		rq = '0;
		ctrl = 16'h0;
		exp = 7'h3f;
		g = 6;
		phi = 6;
		plo = 6;
		lastlo = 0;
		lfsr = 32'h2722;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(4'h0, 16'h0000);
		run(100);
		// Two steady requesters: high rotation, then one of them made low
		want <= 7'h03;
		repeat (20) @(posedge clk);
		wr(4'h0, 16'h0002);
		repeat (20) @(posedge clk);
		want <= 7'h00;
		repeat (10) @(posedge clk);
		wr(4'h0, 16'h007f);
		wr(4'h1, 16'hffff);
		rd(4'h9, 16'h0000);
		rd(4'h0, 16'h007f);
		run(100);
		@(negedge clk);
		check({15'h0, oi.oe}, 16'h0001);
		check(oi.ad[31:16] | oi.ad[15:0], 16'h0000);
		check({11'h0, oi.cbe_n, oi.par}, 16'h0000);
		rd(4'h1, 16'h0340);
		wr(4'h0, 16'h0155);
		run(100);
		rd(4'h0, 16'h0155);
		report_and_stop;
	end
endmodule : pci_segment_arbiter_bench
